// [seggp_pkg.sv]
// Constants, offsets and the state record for the segment-shared GPIO ports.
// Assumes a single system clock and an Avalon-MM master addressing bytes.
package seggp_pkg;

  // Byte offsets of the register words
  localparam logic [5:0] OFF_LCD_CONTROL   = 6'h00;  // LCD control
  localparam logic [5:0] OFF_SEG_24_31     = 6'h04;  // Segment enables 24..31
  localparam logic [5:0] OFF_SEG_32_39     = 6'h08;  // Segment enables 32..39
  localparam logic [5:0] OFF_SEG_40_41     = 6'h0c;  // Segment enables 40..41
  localparam logic [5:0] OFF_SIX_DATA      = 6'h10;  // Port six data
  localparam logic [5:0] OFF_SIX_DIR       = 6'h14;  // Port six direction
  localparam logic [5:0] OFF_SEVEN_DATA    = 6'h18;  // Port seven data
  localparam logic [5:0] OFF_SEVEN_DIR     = 6'h1c;  // Port seven direction

  // Values after reset
  localparam logic [7:0] RST_LCD_CONTROL   = 8'h13;  // Both reset kinds
  localparam logic [7:0] RST_SIX_DIR       = 8'hff;  // All inputs
  localparam logic [5:0] RST_SEVEN_DIR     = 6'h3f;  // All inputs
  localparam logic [7:0] RST_SEG_ENABLE    = 8'h00;  // Power-on only
  localparam logic [7:0] RST_DATA_LATCH    = 8'h00;  // Stands in for unknown

  // Field positions
  localparam int LCD_ENABLE_BIT = 7;                 // LCD module on
  localparam int SEG_LOW_BASE   = 4;                 // Segment 28 in enable 24..31

  // Complete register image, one flop group per field
  typedef struct packed {
    logic        waitReq;        // Bus wait flag
    logic [31:0] readData;       // Bus read word
    logic [7:0]  lcdControl;     // LCD control
    logic [7:0]  segEnable24;    // Segment enables 24..31
    logic [7:0]  segEnable32;    // Segment enables 32..39
    logic [1:0]  segEnable40;    // Segment enables 40..41
    logic [7:0]  sixData;        // Port six output latch
    logic [7:0]  sixDir;         // Port six direction
    logic [5:0]  sevenData;      // Port seven output latch
    logic [5:0]  sevenDir;       // Port seven direction
    logic [7:0]  sixMeta;        // Port six first sync stage
    logic [7:0]  sixSync;        // Port six sensed level
    logic [5:0]  sevenMeta;      // Port seven first sync stage
    logic [5:0]  sevenSync;      // Port seven sensed level
    logic [7:0]  sixOut;         // Port six pin drive value
    logic [7:0]  sixOe;          // Port six pin enables
    logic [5:0]  sevenOut;       // Port seven pin drive value
    logic [5:0]  sevenOe;        // Port seven pin enables
  } seggp_state_t;

endpackage

// [seggp_ports.sv]
// Two GPIO ports sharing pins with LCD segment outputs, behind an Avalon-MM slave.
// Assumes segment waveforms arrive on clk_sys from the LCD controller and
// that pin levels arrive asynchronously and are synchronised here.
// Limitation: a pin read lags the pin by two clocks plus the read capture,
// so software that toggles a pin and reads it back at once sees the old level.
`timescale 1ns/10ps

module seggp_ports
  import seggp_pkg::*;
(
  input  wire logic        clk_sys,         // System clock, 125 MHz
  input  wire logic        reset,           // Ordinary reset, sync, high
  input  wire logic        porReset,        // Power-on / brown-out reset, sync, high
  input  wire logic [5:0]  address,         // Byte address
  input  wire logic        read,            // Read request
  input  wire logic        write,           // Write request
  input  wire logic [31:0] writedata,       // Write word
  input  wire logic [3:0]  byteenable,      // Byte lanes
  output logic      [31:0] readdata,        // Read word
  output logic             waitrequest,     // Stall while high
  input  wire logic [13:0] lcdSegmentOutput, // Segment levels 28..41, bit 0 is 28
  input  wire logic [7:0]  portSixPinsIn,   // Port six pin levels
  output logic      [7:0]  portSixPinsOut,  // Port six drive values
  output logic      [7:0]  portSixPinsOe,   // Port six enables, high drives
  input  wire logic [5:0]  portSevenPinsIn, // Port seven pin levels
  output logic      [5:0]  portSevenPinsOut, // Port seven drive values
  output logic      [5:0]  portSevenPinsOe  // Port seven enables, high drives
);

  seggp_state_t state_reg;   // Registered state
  seggp_state_t state_next;  // Next state
  logic         busReq;      // Any request present
  logic         wrTake;      // Write completes this edge
  logic         lcdOn;       // LCD module enabled
  logic [7:0]   sixSegAct;   // Port six pins owned by segments
  logic [5:0]   sevenSegAct; // Port seven pins owned by segments
  logic [7:0]   sixSegVal;   // Segment level per port six pin
  logic [5:0]   sevenSegVal; // Segment level per port seven pin
  logic [7:0]   rdByte;      // Decoded read byte

  // Byte-lane merge; only lane 0 carries register data
  // Every register fits in one byte, so the other lanes are ignored rather
  // than refused; the bus still completes the transfer.
  function automatic logic [7:0] laneMerge(input logic [7:0] oldVal,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    laneMerge = be[0] ? wd[7:0] : oldVal;
  endfunction

  // Segment ownership and pin mapping
  // A pin belongs to the LCD only while both its enable bit and the global
  // LCD enable are set; clearing the global bit hands every pin back at once,
  // which keeps the port usable while the panel is switched off.
  always_comb begin
    lcdOn       = state_reg.lcdControl[LCD_ENABLE_BIT];
    // Low nibble goes to segments 32..35, high nibble to 28..31
    sixSegAct   = {state_reg.segEnable24[7:SEG_LOW_BASE],
                   state_reg.segEnable32[3:0]} & {8{lcdOn}};
    sixSegVal   = {lcdSegmentOutput[3:0], lcdSegmentOutput[7:4]};
    // Bits 0..5 go to segments 36..41 in order
    sevenSegAct = {state_reg.segEnable40,
                   state_reg.segEnable32[7:4]} & {6{lcdOn}};
    sevenSegVal = lcdSegmentOutput[13:8];
  end

  // Read decoding; unmapped addresses read zero
  // Data addresses return the sensed pin, not the latch, so a driven pin that
  // is held by something outside reads back its real level.
  // The decode is combinational; the word is registered in the next-state logic.
  always_comb begin
    rdByte = 8'h00;
    if (address == OFF_LCD_CONTROL) begin
      rdByte = state_reg.lcdControl;
    end else if (address == OFF_SEG_24_31) begin
      rdByte = state_reg.segEnable24;
    end else if (address == OFF_SEG_32_39) begin
      rdByte = state_reg.segEnable32;
    end else if (address == OFF_SEG_40_41) begin
      rdByte = {6'h00, state_reg.segEnable40};
    end else if (address == OFF_SIX_DATA) begin
      rdByte = state_reg.sixSync;
    end else if (address == OFF_SIX_DIR) begin
      rdByte = state_reg.sixDir;
    end else if (address == OFF_SEVEN_DATA) begin
      rdByte = {2'b00, state_reg.sevenSync};
    end else if (address == OFF_SEVEN_DIR) begin
      rdByte = {2'b00, state_reg.sevenDir};
    end
  end

  // Next-state logic for bus, registers, synchronisers and pins
  // Bus timing: a request seen with the wait flag high is taken; the flag
  // drops for the following cycle and the master completes at the edge that
  // ends it. Writes land at that completing edge, reads were captured one
  // edge earlier so the word already stands. One wait state is the price of
  // registering both waitrequest and readdata.
  always_comb begin
    state_next = state_reg;
    busReq     = read | write;
    // The wait flag drops for exactly one cycle per request
    wrTake     = write & ~state_reg.waitReq;
    state_next.waitReq = ~(busReq & state_reg.waitReq);
    if (read && state_reg.waitReq) begin
      // Captured one cycle ahead so the word stands at the completing edge
      state_next.readData = {24'h000000, rdByte};
    end

    // Register writes at the completing edge only
    if (wrTake) begin
      if (address == OFF_LCD_CONTROL) begin
        state_next.lcdControl = laneMerge(state_reg.lcdControl, writedata, byteenable);
      end else if (address == OFF_SEG_24_31) begin
        state_next.segEnable24 = laneMerge(state_reg.segEnable24, writedata, byteenable);
      end else if (address == OFF_SEG_32_39) begin
        state_next.segEnable32 = laneMerge(state_reg.segEnable32, writedata, byteenable);
      end else if (address == OFF_SEG_40_41) begin
        state_next.segEnable40 = byteenable[0] ? writedata[1:0] : state_reg.segEnable40;
      end else if (address == OFF_SIX_DATA) begin
        state_next.sixData = laneMerge(state_reg.sixData, writedata, byteenable);
      end else if (address == OFF_SIX_DIR) begin
        state_next.sixDir = laneMerge(state_reg.sixDir, writedata, byteenable);
      end else if (address == OFF_SEVEN_DATA) begin
        // Upper two bits do not exist, so writes to them vanish
        state_next.sevenData = byteenable[0] ? writedata[5:0] : state_reg.sevenData;
      end else if (address == OFF_SEVEN_DIR) begin
        state_next.sevenDir = byteenable[0] ? writedata[5:0] : state_reg.sevenDir;
      end
    end

    // Two-stage pin synchronisers; only the second stage is read
    state_next.sixMeta   = portSixPinsIn;
    state_next.sixSync   = state_reg.sixMeta;
    state_next.sevenMeta = portSevenPinsIn;
    state_next.sevenSync = state_reg.sevenMeta;

    // Pin drive: segment wins over latch, direction zero enables the driver
    // A segment-owned pin is always driven whatever its direction bit says,
    // because the panel needs the waveform even while the port is an input.
    // Registering the drive costs one clock of latency after a write.
    state_next.sixOut   = (sixSegAct & sixSegVal) | (~sixSegAct & state_reg.sixData);
    state_next.sixOe    = sixSegAct | ~state_reg.sixDir;
    state_next.sevenOut = (sevenSegAct & sevenSegVal)
                        | (~sevenSegAct & state_reg.sevenData);
    state_next.sevenOe  = sevenSegAct | ~state_reg.sevenDir;

    // Ordinary reset: directions and LCD control forced, latches kept
    // Latches and segment enables are left alone on purpose, so a
    // late reset does not lose outputs that software already set up;
    // the drivers drop because the enables are forced low and every direction returns to input with the LCD off.
    if (reset) begin
      state_next.waitReq    = 1'b1;
      state_next.readData   = 32'h00000000;
      state_next.lcdControl = RST_LCD_CONTROL;
      state_next.sixDir     = RST_SIX_DIR;
      state_next.sevenDir   = RST_SEVEN_DIR;
      state_next.sixOe      = 8'h00;
      state_next.sevenOe    = 6'h00;
    end
    // Power-on reset loads every field; data latches stand in for unknown
    // Zero is one legal choice for an unknown latch; software must still
    // write the latch before turning a pin into an output.
    if (porReset) begin
      state_next.waitReq     = 1'b1;
      state_next.readData    = 32'h00000000;
      state_next.lcdControl  = RST_LCD_CONTROL;
      state_next.segEnable24 = RST_SEG_ENABLE;
      state_next.segEnable32 = RST_SEG_ENABLE;
      state_next.segEnable40 = RST_SEG_ENABLE[1:0];
      state_next.sixData     = RST_DATA_LATCH;
      state_next.sevenData   = RST_DATA_LATCH[5:0];
      state_next.sixDir      = RST_SIX_DIR;
      state_next.sevenDir    = RST_SEVEN_DIR;
      state_next.sixMeta     = 8'h00;
      state_next.sixSync     = 8'h00;
      state_next.sevenMeta   = 6'h00;
      state_next.sevenSync   = 6'h00;
      state_next.sixOut      = 8'h00;
      state_next.sixOe       = 8'h00;
      state_next.sevenOut    = 6'h00;
      state_next.sevenOe     = 6'h00;
    end
  end

  // State register; reset handled synchronously in the next-state logic
  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  // Outputs straight from flops
  // Plain copies, so every top-level output comes from a flop.
  always_comb begin
    readdata         = state_reg.readData;
    waitrequest      = state_reg.waitReq;
    portSixPinsOut   = state_reg.sixOut;
    portSixPinsOe    = state_reg.sixOe;
    portSevenPinsOut = state_reg.sevenOut;
    portSevenPinsOe  = state_reg.sevenOe;
  end

  // Checks on the behaviour above
  // All checks run on clk_sys and sleep through either reset; the reset
  // checks look back one edge with $past, after the reset has dropped.
  // Power-on and latch-keep checks set their own disable so they can see the reset they check.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || porReset);

  // A read of port six data with the wait flag still high
  sequence sixDataAsk;
    read && waitrequest && (address == OFF_SIX_DATA);
  endsequence

  // Completion of that read one edge later
  sequence sixDataDone;
    !waitrequest;
  endsequence

  a_seven_dir_rst: assert property ($past(reset) |-> state_reg.sevenDir == 6'h3f)
    else $error("port seven directions not all inputs after reset");

  a_six_dir_rst: assert property ($past(reset) |-> state_reg.sixDir == 8'hff)
    else $error("port six directions not all inputs after reset");

  a_latch_keep: assert property (@(posedge clk_sys) disable iff (porReset)
    reset |=> (state_reg.sixData == $past(state_reg.sixData))
              && (state_reg.segEnable32 == $past(state_reg.segEnable32)))
    else $error("data latch or segment enable lost on ordinary reset");

  a_seven_oe_dir: assert property (##1 (portSevenPinsOe
      == ($past(sevenSegAct) | ~$past(state_reg.sevenDir))))
    else $error("port seven enable does not follow its direction");

  a_six_tristate: assert property ((state_reg.sixDir == 8'hff) && !lcdOn
      |=> portSixPinsOe == 8'h00)
    else $error("port six driven while all inputs");

  a_seven_upper_zero: assert property (read && !waitrequest
      && ((address == OFF_SEVEN_DATA) || (address == OFF_SEVEN_DIR))
      |-> readdata[31:6] == 26'h0000000)
    else $error("port seven upper bits not zero");

  a_six_read_pin: assert property (sixDataAsk ##1 sixDataDone
      |-> readdata[7:0] == $past(state_reg.sixSync))
    else $error("port six read is not the pin level");

  a_lcd_segment_output_map: assert property (lcdOn && state_reg.segEnable24[4]
      |=> portSixPinsOut[4] == $past(lcdSegmentOutput[0]))
    else $error("segment 28 not on port six bit 4");

  a_seg36_map: assert property (lcdOn && state_reg.segEnable32[4]
      |=> portSevenPinsOut[0] == $past(lcdSegmentOutput[8]))
    else $error("segment 36 not on port seven bit 0");

  a_lcd_off_latch: assert property (!lcdOn
      |=> portSixPinsOut == $past(state_reg.sixData))
    else $error("port six output not from latch with LCD off");

  a_wait_pulse: assert property ((read || write) && waitrequest
      |=> !waitrequest ##1 waitrequest)
    else $error("wait flag low for other than one cycle");

  // A read of port seven data with the wait flag still high
  sequence sevenDataAsk;
    read && waitrequest && (address == OFF_SEVEN_DATA);
  endsequence

  // A completing write to port six direction on lane 0
  sequence sixDirWrite;
    write && !waitrequest && (address == OFF_SIX_DIR) && byteenable[0];
  endsequence

  // A completing write to port seven direction on lane 0
  sequence sevenDirWrite;
    write && !waitrequest && (address == OFF_SEVEN_DIR) && byteenable[0];
  endsequence

  // Power-on and brown-out clear the data latches
  a_por_latch_clear: assert property (@(posedge clk_sys) disable iff (reset)
    $past(porReset) |-> (state_reg.sixData == RST_DATA_LATCH)
                        && (state_reg.sevenData == RST_DATA_LATCH[5:0]))
    else $error("data latch not cleared by power-on reset");

  // Power-on and brown-out clear the segment enables
  a_por_seg_clear: assert property (@(posedge clk_sys) disable iff (reset)
    $past(porReset) |-> (state_reg.segEnable24 == RST_SEG_ENABLE)
                        && (state_reg.segEnable32 == RST_SEG_ENABLE))
    else $error("segment enable not cleared by power-on reset");

  // Port six enable follows its own direction bits
  a_six_oe_dir: assert property (##1 (portSixPinsOe
      == ($past(sixSegAct) | ~$past(state_reg.sixDir))))
    else $error("port six enable does not follow its direction");

  // Port seven read returns the sensed level with the upper bits clear
  a_seven_read_pin: assert property (sevenDataAsk ##1 sixDataDone
      |-> readdata[7:0] == {2'b00, $past(state_reg.sevenSync)})
    else $error("port seven read is not the pin level");

  // A port six direction write lands whole
  a_six_dir_write: assert property (sixDirWrite
      |=> state_reg.sixDir == $past(writedata[7:0]))
    else $error("port six direction write lost");

  // Each port seven direction bit takes its own written value
  a_seven_dir_write: assert property (sevenDirWrite
      |=> state_reg.sevenDir == $past(writedata[5:0]))
    else $error("port seven direction write lost");

  // Segment 32 appears on port six bit 0
  a_seg32_map: assert property (lcdOn && state_reg.segEnable32[0]
      |=> portSixPinsOut[0] == $past(lcdSegmentOutput[4]))
    else $error("segment 32 not on port six bit 0");

  // Segment 41 appears on port seven bit 5
  a_seg41_map: assert property (lcdOn && state_reg.segEnable40[1]
      |=> portSevenPinsOut[5] == $past(lcdSegmentOutput[13]))
    else $error("segment 41 not on port seven bit 5");

  // An owned pin is driven even while its direction says input
  a_seg_oe_force: assert property (lcdOn && state_reg.segEnable24[4]
      |=> portSixPinsOe[4])
    else $error("segment-owned pin not driven");

  // With the LCD off port seven drives its latch
  a_seven_lcd_off: assert property (!lcdOn
      |=> portSevenPinsOut == $past(state_reg.sevenData))
    else $error("port seven output not from latch with LCD off");

  // Port seven released while all inputs and no segment owns a pin
  a_seven_tristate: assert property ((state_reg.sevenDir == RST_SEVEN_DIR) && !lcdOn
      |=> portSevenPinsOe == 6'h00)
    else $error("port seven driven while all inputs");

  // Every read word carries one byte in lane 0
  a_read_upper_zero: assert property (read && !waitrequest
      |-> readdata[31:8] == 24'h000000)
    else $error("read word has bits above the low byte");

  // With no request the wait flag stays high
  a_wait_idle: assert property (!read && !write && waitrequest
      |=> waitrequest)
    else $error("wait flag dropped without a request");

  // Ordinary reset keeps port seven latch and the top segment enables
  a_latch_keep_seven: assert property (@(posedge clk_sys) disable iff (porReset)
    reset |=> (state_reg.sevenData == $past(state_reg.sevenData))
              && (state_reg.segEnable40 == $past(state_reg.segEnable40)))
    else $error("port seven latch or segment enable lost on ordinary reset");

endmodule

// [seggp_ports_tb.sv]
// Self-checking bench for the segment-shared GPIO ports block.
// Assumes the design's own Avalon-MM slave answers with one wait cycle.
// Pin levels are resolved here from the design's enables and outside drivers.
`timescale 1ns/10ps

module tb
  import seggp_pkg::*;
;
  logic        clk_sys, reset, porReset, read, write, waitrequest;  // Clock, resets, bus
  logic [5:0]  address;                                             // Byte address
  logic [31:0] writedata, readdata;                                 // Bus words
  logic [3:0]  byteenable;                                          // Byte lanes
  logic [13:0] lcdSegmentOutput;                                    // Segment levels 28..41
  logic [7:0]  sixExt, portSixPinsIn, portSixPinsOut, portSixPinsOe;        // Port six
  logic [5:0]  sevenExt, portSevenPinsIn, portSevenPinsOut, portSevenPinsOe; // Port seven
  int          mismatches, checked;                                 // Counters
  logic [31:0] q;                                                   // Last read word

  // A driven pin shows the design's value, a released one the outside level
  assign portSixPinsIn   = (portSixPinsOut & portSixPinsOe) | (sixExt & ~portSixPinsOe);
  assign portSevenPinsIn = (portSevenPinsOut & portSevenPinsOe) | (sevenExt & ~portSevenPinsOe);

  seggp_ports i_seggp_ports (.clk_sys(clk_sys), .reset(reset), .porReset(porReset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .lcdSegmentOutput(lcdSegmentOutput), .portSixPinsIn(portSixPinsIn),
    .portSixPinsOut(portSixPinsOut), .portSixPinsOe(portSixPinsOe),
    .portSevenPinsIn(portSevenPinsIn), .portSevenPinsOut(portSevenPinsOut),
    .portSevenPinsOe(portSevenPinsOe));

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  // Prints the counts and the verdict, then stops
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Single comparison point; four-state equality so an unknown bit never matches a known expected bit
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle: held until waitrequest is sampled low, released at that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    address    <= a;
    write      <= wr;
    read       <= ~wr;
    writedata  <= {24'h0, d};
    byteenable <= be;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // Register write and checked register read
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(q, {24'h0, exp});
  endtask

  // Lets register changes reach the pins; samples away from the rising edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Hung bus or design cuts the run short
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end

  initial begin
    clk_sys = 0; reset = 1; porReset = 1; address = 6'h00; read = 0; write = 0;
    writedata = 32'h0; byteenable = 4'h0; lcdSegmentOutput = 14'h0000;
    sixExt = 8'h3c; sevenExt = 6'h2a; mismatches = 0; checked = 0;
    repeat (5) @(posedge clk_sys);
    reset    <= 1'b0;
    porReset <= 1'b0;
    // Power-on values: every pin released, enables cleared
    rd(OFF_SIX_DIR, 8'hff);
    rd(OFF_SEVEN_DIR, 8'h3f);
    rd(OFF_LCD_CONTROL, 8'h13);
    rd(OFF_SEG_24_31, 8'h00);
    rd(OFF_SEG_32_39, 8'h00);
    rd(OFF_SEG_40_41, 8'h00);
    chk({portSevenPinsOe, portSixPinsOe}, 32'h0);
    $display("test reset values done");
    // Mixed directions; upper bits of port seven must stay zero
    wr(OFF_SIX_DATA, 8'ha5);
    wr(OFF_SEVEN_DATA, 8'hff);
    wr(OFF_SIX_DIR, 8'h5a);
    wr(OFF_SEVEN_DIR, 8'hc6);
    rd(OFF_SEVEN_DIR, 8'h06);
    rd(OFF_SEVEN_DATA, 8'h3b);
    settle(2);
    chk(portSixPinsOe, 8'ha5);
    chk(portSixPinsOut & portSixPinsOe, 8'ha5);
    chk(portSevenPinsOe, 6'h39);
    chk(portSevenPinsOut & portSevenPinsOe, 6'h39);
    // Reads show pin levels: driven bits from latch, released bits from outside
    rd(OFF_SIX_DATA, 8'hbd);
    sevenExt <= 6'h04;
    settle(3);
    rd(OFF_SEVEN_DATA, 8'h3d);
    // Unmapped place and a write with its lane off are both ignored
    wr(6'h20, 8'hff);
    rd(6'h20, 8'h00);
    bus(1'b1, OFF_SIX_DIR, 8'h00, 4'h0);
    rd(OFF_SIX_DIR, 8'h5a);
    $display("test directions done");
    // Segments 28, 33, 37 and 41 take their pins once the LCD is on
    wr(OFF_SEG_24_31, 8'h10);
    wr(OFF_SEG_32_39, 8'h22);
    wr(OFF_SEG_40_41, 8'h02);
    lcdSegmentOutput <= 14'h2221;
    wr(OFF_LCD_CONTROL, 8'h93);
    settle(2);
    chk(portSixPinsOe, 8'hb7);
    chk(portSixPinsOut & portSixPinsOe, 8'hb7);
    chk(portSevenPinsOe, 6'h3b);
    chk(portSevenPinsOut & portSevenPinsOe, 6'h3b);
    lcdSegmentOutput <= 14'h0000;
    settle(2);
    chk(portSixPinsOut & portSixPinsOe, 8'ha5);
    chk(portSevenPinsOut & portSevenPinsOe, 6'h19);
    wr(OFF_LCD_CONTROL, 8'h13);
    settle(2);
    chk({portSevenPinsOe, portSixPinsOe}, 32'h39a5);
    $display("test segments done");
    // Ordinary reset: directions back to inputs, latches and enables kept
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFF_SIX_DIR, 8'hff);
    rd(OFF_SEVEN_DIR, 8'h3f);
    rd(OFF_LCD_CONTROL, 8'h13);
    rd(OFF_SEG_24_31, 8'h10);
    rd(OFF_SEG_32_39, 8'h22);
    rd(OFF_SEG_40_41, 8'h02);
    wr(OFF_SIX_DIR, 8'h00);
    wr(OFF_SEVEN_DIR, 8'h00);
    settle(2);
    chk(portSixPinsOut, 8'ha5);
    chk(portSevenPinsOut, 6'h3f);
    $display("test ordinary reset done");
    // Power-on reset: latches and segment enables cleared as well
    @(posedge clk_sys);
    porReset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    porReset <= 1'b0;
    rd(OFF_SIX_DIR, 8'hff);
    rd(OFF_SEG_32_39, 8'h00);
    rd(OFF_SEG_40_41, 8'h00);
    wr(OFF_SIX_DIR, 8'h00);
    wr(OFF_SEVEN_DIR, 8'h00);
    settle(2);
    chk(portSixPinsOut, 8'h00);
    chk(portSevenPinsOut, 6'h00);
    $display("test power-on reset done");
    wrap_up();
  end
endmodule
